// ==== sim/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb
    import timer_irq_pkg::*;
;
    typedef struct packed {
        logic [1:0] tmr;
        logic [3:0] eoc;
        logic [3:0] cm;
        logic cmode;
        logic pmode;
        logic trip;
        logic [7:0] exp;
    } row_t;

    // ----------------------------------------
    // Event rows: timer, inputs, flag byte expected on read
    // ----------------------------------------
    localparam row_t ROWS [8] = '{
        '{2'h0, 4'h1, 4'h0, 1'h0, 1'h0, 1'h0, 8'h01},
        '{2'h1, 4'h2, 4'h0, 1'h0, 1'h0, 1'h0, 8'h01},
        '{2'h2, 4'h4, 4'hF, 1'h1, 1'h0, 1'h0, 8'h01},
        '{2'h3, 4'h0, 4'hF, 1'h1, 1'h0, 1'h0, 8'h78},
        '{2'h3, 4'h0, 4'h5, 1'h0, 1'h0, 1'h0, 8'h00},
        '{2'h3, 4'h0, 4'h0, 1'h0, 1'h1, 1'h1, 8'h02},
        '{2'h3, 4'h0, 4'h0, 1'h0, 1'h0, 1'h1, 8'h00},
        '{2'h3, 4'h8, 4'h9, 1'h1, 1'h0, 1'h0, 8'h49}
    };
    localparam logic [3:0] CAP_IRQ [4] = '{4'h0, 4'h2, 4'h8, 4'h0};

    logic clk = 1'h0;
    logic rstB = 1'h0;
    logic ce = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [8:0] adr = 9'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic ack;
    logic [3:0] endOfCount = 4'h0;
    logic [3:0] compareMatch = 4'h0;
    logic [3:0] captureMode = 4'h0;
    logic compareMode = 1'h0;
    logic pwmMode = 1'h0;
    logic powerTrip = 1'h0;
    logic [3:0] capturePin = 4'h0;
    logic [3:0] captureRise = 4'hF;
    logic [3:0] irqTimer;
    logic irq;
    int failures = 0;
    int n_checks = 0;

    timer_irq_enable_flags DUT (.clk(clk), .rst_b(rstB), .ce(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
        .endOfCount(endOfCount), .compareMatch(compareMatch), .captureMode(captureMode),
        .compareMode(compareMode), .pwmMode(pwmMode), .powerTrip(powerTrip),
        .capturePin(capturePin), .captureRise(captureRise), .irqTimer(irqTimer), .irq(irq));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle; waits for ack, never assumes a latency
    task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        datW <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'h1 && n < 20);
        if (ack !== 1'h1)
            failures++;
        q = datR;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk);
    endtask

    task automatic fire(input row_t r);
        endOfCount <= r.eoc;
        compareMatch <= r.cm;
        compareMode <= r.cmode;
        pwmMode <= r.pmode;
        powerTrip <= r.trip;
        @(posedge clk);
        endOfCount <= 4'h0;
        compareMatch <= 4'h0;
        powerTrip <= 1'h0;
        @(posedge clk);
    endtask

    task automatic chkIrq(input logic [3:0] e);
        chk({27'h0, irq, irqTimer}, {27'h0, |e, e});
    endtask

    function automatic logic [8:0] fa(input int t);
        return {FLAG_IDX[t], 2'h0};
    endfunction

    function automatic logic [8:0] ea(input int t);
        return {EN_IDX[t], 2'h0};
    endfunction

    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] q;
        repeat (3) @(posedge clk);
        rstB <= 1'h1;
        @(posedge clk);
        for (int t = 0; t < 4; t++)
        begin
            wb(1'h0, fa(t), 8'h00, q);
            chk(q, {24'h0, FLAG_RESET});
            wb(1'h0, ea(t), 8'h00, q);
            chk(q, {24'h0, EN_RESET});
        end
        foreach (ROWS[i])
        begin
            fire(ROWS[i]);
            wb(1'h0, fa(ROWS[i].tmr), 8'h00, q);
            chk(q, {24'h0, ROWS[i].exp});
            wb(1'h0, fa(ROWS[i].tmr), 8'h00, q);
            chk(q, 32'h0);
        end
        // Enable bit 7 is not stored; unmapped words read zero
        wb(1'h1, ea(2), 8'hFF, q);
        wb(1'h0, ea(2), 8'h00, q);
        chk(q, {24'h0, EN_WRITABLE});
        wb(1'h1, ea(2), 8'h00, q);
        wb(1'h1, 9'h1FC, 8'hFF, q);
        wb(1'h0, 9'h1FC, 8'h00, q);
        chk(q, 32'h0);
        // End-of-count request, enabled then disabled
        wb(1'h1, ea(0), 8'h01, q);
        fire(ROWS[0]);
        chkIrq(4'h1);
        wb(1'h0, fa(0), 8'h00, q);
        chk(q, 32'h1);
        chkIrq(4'h0);
        wb(1'h1, ea(0), 8'h00, q);
        fire(ROWS[0]);
        chkIrq(4'h0);
        wb(1'h0, fa(0), 8'h00, q);
        chk(q, 32'h1);
        // Writing a one clears a flag; a frozen clock enable drops events
        fire(ROWS[0]);
        wb(1'h1, fa(0), 8'h01, q);
        wb(1'h0, fa(0), 8'h00, q);
        chk(q, 32'h0);
        ce <= 1'h0;
        fire(ROWS[0]);
        ce <= 1'h1;
        wb(1'h0, fa(0), 8'h00, q);
        chk(q, 32'h0);
        // Capture pins: timer 1 enables B only, timer 3 enables A only
        wb(1'h1, ea(1), 8'h04, q);
        wb(1'h1, ea(3), 8'h02, q);
        captureMode <= 4'hA;
        for (int p = 0; p < 4; p++)
        begin
            capturePin[p] <= 1'h1;
            repeat (6) @(posedge clk);
            chkIrq(CAP_IRQ[p]);
            wb(1'h0, fa(p < 2 ? 1 : 3), 8'h00, q);
            chk(q, p[0] ? 32'h4 : 32'h2);
            chkIrq(4'h0);
            capturePin[p] <= 1'h0;
            repeat (6) @(posedge clk);
        end
        // Without capture mode a pin edge is ignored
        captureMode <= 4'h0;
        capturePin[1] <= 1'h1;
        repeat (6) @(posedge clk);
        wb(1'h0, fa(1), 8'h00, q);
        chk(q, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire

// ==== src/pin_edge_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync
    import timer_irq_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic clk,                 // System clock
    input wire logic rst_b,               // Synchronous reset, active low
    input wire logic ce,                  // Clock enable
    input wire logic [WIDTH-1:0] pinIn,   // Asynchronous pins
    output logic [WIDTH-1:0] rise,        // One-cycle rising-edge event
    output logic [WIDTH-1:0] fall         // One-cycle falling-edge event
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else if (ce)
        begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            level_q <= '0;
        else if (ce)
            level_q <= (agree & s3_q) | (~agree & level_q);
    end

    assign rise = agree & s3_q & ~level_q;
    assign fall = agree & ~s3_q & level_q;

endmodule

`default_nettype wire

// ==== src/timer_irq_enable_flags.sv ====
// What this block does
// [RULE1] Enable bit 2 gates capture B, capture mode
// [RULE2] Enable bit 1 gates capture A or trip
// [RULE3] Enable bit 0 gates end-of-count request
// [RULE4] Capture B uses pin one or three
// [RULE5] Capture A uses pin zero or two
// [RULE6] Reading flags returns them, then clears all
// [RULE7] Bits 6..3 flag compare matches; 7 zero
// [RULE8] Bit 2 flags a capture B event
// [RULE9] Bit 1 flags capture A or trip
// [RULE10] Bit 0 flags end of count
// [RULE11] Compare bits live only on timer 3
// [RULE12] Request while enabled flag set; drops on read
`timescale 1ns/100ps
`default_nettype none

module timer_irq_enable_flags
    import timer_irq_pkg::*;
#(
    parameter int ADDR_W = 9
)
(
    input wire logic clk,                          // System clock, 50 MHz
    input wire logic rst_b,                        // Synchronous reset, active low
    input wire logic ce,                           // Clock enable, freezes all state
    input wire logic cyc_i,                        // Wishbone cycle
    input wire logic stb_i,                        // Wishbone strobe
    input wire logic we_i,                         // Wishbone write enable
    input wire logic [ADDR_W-1:0] adr_i,           // Wishbone byte address
    input wire logic [3:0] sel_i,                  // Wishbone byte selects
    input wire logic [31:0] dat_i,                 // Wishbone write data
    output logic [31:0] dat_o,                     // Wishbone read data
    output logic ack_o,                            // Wishbone acknowledge
    input wire logic [TIMER_N-1:0] endOfCount,     // End-of-count pulse per timer
    input wire logic [3:0] compareMatch,           // Timer 3 compare match pulses
    input wire logic [TIMER_N-1:0] captureMode,    // Timer is in capture mode
    input wire logic compareMode,                  // Timer 3 in compare mode
    input wire logic pwmMode,                      // Timer 3 in PWM mode
    input wire logic powerTrip,                    // PWM power-trip pulse
    input wire logic [PIN_N-1:0] capturePin,       // Capture pins, asynchronous
    input wire logic [PIN_N-1:0] captureRise,      // Edge per pin: 1 rise, 0 fall
    output logic [TIMER_N-1:0] irqTimer,           // Request per timer
    output logic irq                               // Combined request
);

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ack_q;
    logic [31:0] dat_q;
    logic take;
    logic [IDX_W-1:0] wordIdx;
    logic [REG_W-1:0] readVal;
    logic [REG_W-1:0] flags_q [TIMER_N];
    logic [REG_W-1:0] en_q [TIMER_N];
    logic [REG_W-1:0] setVec [TIMER_N];
    logic [REG_W-1:0] effEn [TIMER_N];
    logic [TIMER_N-1:0] rdClr;
    logic [TIMER_N-1:0] wrFlag;
    logic [TIMER_N-1:0] wrEn;
    logic [PIN_N-1:0] pinRise;
    logic [PIN_N-1:0] pinFall;
    logic [PIN_N-1:0] capEvt;

    function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    assign wordIdx = adr_i[ADDR_W-1:2];
    // Answer one cycle after the strobe; the ack gap stops a double take
    assign take = ce && cyc_i && stb_i && !ack_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ack_q <= 1'b0;
        else if (ce)
            ack_q <= take;
    end

    always_comb
    begin
        readVal = '0;
        for (int t = 0; t < TIMER_N; t++)
        begin
            if (hit(wordIdx, FLAG_IDX[t]))
                readVal = flags_q[t];
            if (hit(wordIdx, EN_IDX[t]))
                readVal = en_q[t];
        end
    end

    // Unmapped words read as zero and are still acknowledged
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            dat_q <= 32'h0;
        else if (take && !we_i)
            dat_q <= {24'h0, readVal};
    end

    // ----------------------------------------
    // Capture pins
    // ----------------------------------------
    pin_edge_sync #(
        .WIDTH(PIN_N)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .pinIn(capturePin),
        .rise(pinRise),
        .fall(pinFall)
    );

    assign capEvt = (captureRise & pinRise) | (~captureRise & pinFall);

    // ----------------------------------------
    // Per-timer flags and enables
    // ----------------------------------------
    generate
        for (genvar t = 0; t < TIMER_N; t++)
        begin : g_timer
            localparam logic IS_CAP = HAS_CAPTURE[t];
            localparam logic IS_OC = (t == COMPARE_TIMER);
            localparam logic IS_PWM = (t == PWM_TIMER);
            logic trip;

            assign trip = IS_PWM && pwmMode && powerTrip;
            assign rdClr[t] = take && !we_i && sel_i[0] && hit(wordIdx, FLAG_IDX[t]); // see [RULE6]
            assign wrFlag[t] = take && we_i && sel_i[0] && hit(wordIdx, FLAG_IDX[t]);
            assign wrEn[t] = take && we_i && sel_i[0] && hit(wordIdx, EN_IDX[t]);

            always_comb
            begin
                setVec[t] = '0;
                setVec[t][BIT_EOC] = endOfCount[t]; // see [RULE10]
                setVec[t][BIT_CAPB] = IS_CAP && captureMode[t]
                    && capEvt[CAP_B_PIN[t]]; // see [RULE8] see [RULE4]
                setVec[t][BIT_CAPA] = (IS_CAP && captureMode[t]
                    && capEvt[CAP_A_PIN[t]]) || trip; // see [RULE9] see [RULE5]
                if (IS_OC && compareMode)
                    setVec[t][BIT_OC_HI:BIT_OC_LO] = compareMatch; // see [RULE7] see [RULE11]
            end

            // A new event in the clearing cycle survives the clear
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                    flags_q[t] <= FLAG_RESET;
                else if (ce)
                begin
                    if (rdClr[t])
                        flags_q[t] <= setVec[t]; // see [RULE6]
                    else if (wrFlag[t])
                        flags_q[t] <= (flags_q[t] & ~dat_i[REG_W-1:0]) | setVec[t];
                    else
                        flags_q[t] <= flags_q[t] | setVec[t];
                end
            end

            always_ff @(posedge clk)
            begin
                if (!rst_b)
                    en_q[t] <= EN_RESET;
                else if (ce && wrEn[t])
                    en_q[t] <= dat_i[REG_W-1:0] & EN_WRITABLE;
            end

            // Enables count only in the modes that own the source
            always_comb
            begin
                effEn[t] = '0;
                effEn[t][BIT_EOC] = en_q[t][BIT_EOC]; // see [RULE3]
                effEn[t][BIT_CAPB] = IS_CAP && captureMode[t]
                    && en_q[t][BIT_CAPB]; // see [RULE1]
                effEn[t][BIT_CAPA] = ((IS_CAP && captureMode[t]) || (IS_PWM && pwmMode))
                    && en_q[t][BIT_CAPA]; // see [RULE2]
                if (IS_OC && compareMode)
                    effEn[t][BIT_OC_HI:BIT_OC_LO] = en_q[t][BIT_OC_HI:BIT_OC_LO]; // see [RULE11]
            end

            assign irqTimer[t] = |(flags_q[t] & effEn[t]); // see [RULE12]
        end
    endgenerate

    assign irq = |irqTimer;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_capb_gated: assert property (!captureMode[1] && flags_q[1] == 8'h04 |-> !irqTimer[1]) // see [RULE1]
        else $error("capture B request outside capture mode");

    a_capa_gated: assert property (!captureMode[3] && !pwmMode && flags_q[3] == 8'h02
        |-> !irqTimer[3]) // see [RULE2]
        else $error("capture A request outside capture and PWM modes");

    a_eoc_gate: assert property (flags_q[0] == 8'h01 |-> irqTimer[0] == en_q[0][BIT_EOC]) // see [RULE3]
        else $error("end-of-count request does not follow its enable");

    a_capb_route: assert property (ce && capEvt[1] && captureMode[1] |=> flags_q[1][BIT_CAPB]) // see [RULE4]
        else $error("pin one did not flag capture B on timer 1");

    a_capa_route: assert property (ce && capEvt[2] && captureMode[3] |=> flags_q[3][BIT_CAPA]) // see [RULE5]
        else $error("pin two did not flag capture A on timer 3");

    a_read_clear: assert property (ce && rdClr[0] && setVec[0] == 8'h00
        |=> flags_q[0] == 8'h00 && ack_o) // see [RULE6]
        else $error("flag read did not clear timer 0 flags");

    a_read_value: assert property (ce && rdClr[2] |=> dat_o[7:0] == $past(flags_q[2])) // see [RULE6]
        else $error("flag read returned wrong value");

    a_oc_flag: assert property (ce && compareMode && compareMatch[2] |=> flags_q[3][5]) // see [RULE7]
        else $error("compare match 2 did not set bit 5");

    a_bit7_zero: assert property (flags_q[3][BIT_UNUSED] == 1'b0 && en_q[3][BIT_UNUSED] == 1'b0) // see [RULE7]
        else $error("unused bit 7 set");

    a_capb_flag: assert property (ce && captureMode[3] && capEvt[3] |=> flags_q[3][BIT_CAPB]) // see [RULE8]
        else $error("capture B event lost");

    a_trip_flag: assert property (ce && pwmMode && powerTrip |=> flags_q[3][BIT_CAPA]) // see [RULE9]
        else $error("power trip did not set bit 1");

    a_eoc_flag: assert property (ce && endOfCount[2] |=> flags_q[2][BIT_EOC]) // see [RULE10]
        else $error("end of count did not set bit 0");

    a_oc_only_t3: assert property (flags_q[0][6:3] == 4'h0 && flags_q[1][6:3] == 4'h0
        && flags_q[2][6:3] == 4'h0) // see [RULE11]
        else $error("compare flag on a timer without compare");

    a_irq_drop: assert property (ce && rdClr[1] && setVec[1] == 8'h00 |=> !irqTimer[1]) // see [RULE12]
        else $error("request stayed after flag read");

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // A held strobe must not be answered twice in a row
    a_ack_pulse: assert property (ce && ack_o |=> !ack_o)
        else $error("acknowledge lasted more than one cycle");

    a_ack_answer: assert property (ce && cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged in the next cycle");

    a_ack_stray: assert property (ce && !(cyc_i && stb_i) |=> !ack_o)
        else $error("acknowledge without a request");

    // Software may poll the last read word; it must not drift
    a_dat_hold: assert property (ce && !(take && !we_i) |=> $stable(dat_o))
        else $error("read data changed without a read");

    a_dat_upper: assert property (dat_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");

    a_en_write: assert property (ce && wrEn[0]
        |=> en_q[0] == ($past(dat_i[REG_W-1:0]) & EN_WRITABLE))
        else $error("enable write not stored");

    a_ce_freeze: assert property (!ce |=> $stable(flags_q[3]) && $stable(en_q[3]) && $stable(ack_o))
        else $error("state moved while the clock enable was low");

    // ----------------------------------------
    // Routing and gating
    // ----------------------------------------
    a_capb_en_off: assert property (flags_q[1] == 8'h04 && !en_q[1][BIT_CAPB]
        |-> !irqTimer[1]) // see [RULE1]
        else $error("capture B request while its enable is clear");

    a_trip_irq: assert property (pwmMode && flags_q[3] == 8'h02 && en_q[3][BIT_CAPA]
        |-> irqTimer[3]) // see [RULE2]
        else $error("power trip request missing in PWM mode");

    a_eoc_irq: assert property (flags_q[2][BIT_EOC] && en_q[2][BIT_EOC]
        |-> irqTimer[2]) // see [RULE3]
        else $error("enabled end-of-count gave no request");

    a_capa_t1_route: assert property (ce && capEvt[0] && captureMode[1]
        |=> flags_q[1][BIT_CAPA]) // see [RULE5]
        else $error("pin zero did not flag capture A on timer 1");

    a_capb_t3_route: assert property (ce && capEvt[3] && captureMode[3] && !capEvt[2]
        && !pwmMode && flags_q[3][BIT_CAPA] == 1'b0 |=> !flags_q[3][BIT_CAPA]) // see [RULE4]
        else $error("pin three leaked into capture A on timer 3");

    // Outside compare mode the compare flags may only fall, never rise
    a_oc_mode_off: assert property (ce && !compareMode && flags_q[3][6:3] == 4'h0
        |=> flags_q[3][6:3] == 4'h0) // see [RULE11]
        else $error("compare flag set outside compare mode");

    a_oc_irq_mode: assert property (!compareMode && (flags_q[3][2:0] & en_q[3][2:0]) == 3'h0
        |-> !irqTimer[3]) // see [RULE11]
        else $error("compare request outside compare mode");

    a_eoc_t0_flag: assert property (ce && endOfCount[0] |=> flags_q[0][BIT_EOC]) // see [RULE10]
        else $error("end of count lost on timer 0");

    // ----------------------------------------
    // Clear and request
    // ----------------------------------------
    a_read_clear_t3: assert property (ce && rdClr[3] && setVec[3] == 8'h00
        |=> flags_q[3] == 8'h00) // see [RULE6]
        else $error("flag read did not clear timer 3 flags");

    a_set_wins: assert property (ce && rdClr[0] && endOfCount[0]
        |=> flags_q[0][BIT_EOC]) // see [RULE6]
        else $error("event in the clearing cycle was lost");

    a_irq_drop_t0: assert property (ce && rdClr[0] && setVec[0] == 8'h00
        |=> !irqTimer[0]) // see [RULE12]
        else $error("timer 0 request stayed after flag read");

    a_irq_raise: assert property (ce && endOfCount[1] && en_q[1][BIT_EOC] && !wrEn[1]
        |=> irqTimer[1] && irq) // see [RULE12]
        else $error("enabled event raised no request");

    c_read_flags: cover property (ce && rdClr[3] ##1 ack_o);
    c_irq_eoc: cover property (ce && endOfCount[0] && en_q[0][BIT_EOC] ##1 irq);
    c_set_on_clear: cover property (ce && rdClr[1] && setVec[1] != 8'h00);
    c_trip_irq: cover property (pwmMode && irqTimer[3]);
    c_capb_irq: cover property (irqTimer[1] && flags_q[1][BIT_CAPB]);

endmodule

`default_nettype wire

// ==== src/timer_irq_pkg.sv ====
package timer_irq_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int TIMER_N = 4;
    localparam int REG_W = 8;
    localparam int IDX_W = 7;
    localparam int PIN_N = 4;

    // ----------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------
    localparam logic [IDX_W-1:0] FLAG_IDX [TIMER_N] = '{7'h62, 7'h67, 7'h71, 7'h76};
    localparam logic [IDX_W-1:0] EN_IDX [TIMER_N] = '{7'h61, 7'h66, 7'h70, 7'h75};

    // ----------------------------------------
    // Field positions, shared by flags and enables
    // ----------------------------------------
    localparam int BIT_EOC = 0;
    localparam int BIT_CAPA = 1;
    localparam int BIT_CAPB = 2;
    localparam int BIT_OC_LO = 3;
    localparam int BIT_OC_HI = 6;
    localparam int BIT_UNUSED = 7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [REG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [REG_W-1:0] EN_RESET = 8'h00;
    localparam logic [REG_W-1:0] EN_WRITABLE = 8'h7F;

    // ----------------------------------------
    // Which timers own capture and compare logic
    // ----------------------------------------
    localparam logic [TIMER_N-1:0] HAS_CAPTURE = 4'hA;
    localparam int COMPARE_TIMER = 3;
    localparam int PWM_TIMER = 3;
    localparam int CAP_A_PIN [TIMER_N] = '{0, 0, 0, 2};
    localparam int CAP_B_PIN [TIMER_N] = '{0, 1, 0, 3};

    // ----------------------------------------
    // Pin synchroniser depth
    // ----------------------------------------
    localparam int SYNC_STAGES = 3;

endpackage
